// >>> rtl/core_ops_unit.sv
// Execution of rotate, subtract-from-literal and sleep for an 8-bit core.
// Assumes decode presents one operation per cycle with the file operand
// already read; the register file takes FILE_WR_EN with FILE_WR_DATA.
`timescale 1ns/1ps
module core_ops_unit (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Operation request
  input core_ops_pkg::op_req_type REQ,
  output logic REQ_READY,
  // Register file write-back
  output logic FILE_WR_EN,
  output logic [7:0] FILE_WR_DATA,
  // Core state
  output logic [7:0] ACC,
  output core_ops_pkg::status_type STATUS,
  output logic [7:0] WDT_COUNT,
  output logic OSC_RUN
);
  import core_ops_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] acc;
    status_type status;
    logic asleep;
    logic [7:0] watchdog_counter;
    logic [7:0] prescale;
    logic file_wr;
    logic [7:0] file_data;
  } state_type;

  state_type cur;
  state_type next_cur;

  logic take;
  logic [7:0] rotl_result;
  logic rotl_carry;
  logic [7:0] rotr_result;
  logic rotr_carry;
  logic [7:0] sub_diff;
  logic sub_carry;
  logic sub_nibble;
  logic sub_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  rotate_through_carry #(.RIGHT(ROT_LEFT)) u_rotl (
    .operand(REQ.operand),
    .carry_in(cur.status.carry),
    .result(rotl_result),
    .carry_out(rotl_carry)
  );

  rotate_through_carry #(.RIGHT(ROT_RIGHT)) u_rotr (
    .operand(REQ.operand),
    .carry_in(cur.status.carry),
    .result(rotr_result),
    .carry_out(rotr_carry)
  );

  literal_subtractor u_sub (
    .literal(REQ.literal),
    .acc(cur.acc),
    .diff(sub_diff),
    .carry(sub_carry),
    .nibble_carry(sub_nibble),
    .zero(sub_zero)
  );

  // Nothing is taken once asleep; only reset brings the core back
  assign take = REQ.valid && !cur.asleep;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur = cur;
    next_cur.file_wr = 1'h0;
    // Watchdog prescaler runs as a divider of the core clock
    if (cur.prescale == PRESCALE_TOP) begin
      next_cur.prescale = PRESCALE_CLEAR;
      next_cur.watchdog_counter = cur.watchdog_counter + 8'h01;
    end else begin
      next_cur.prescale = cur.prescale + 8'h01;
    end
    if (take) begin
      case (REQ.code)
        rotate_left_op: begin
          next_cur.status.carry = rotl_carry;
          if (REQ.dest == DEST_FILE) begin
            next_cur.file_wr = 1'h1;
            next_cur.file_data = rotl_result;
          end else begin
            next_cur.acc = rotl_result;
          end
        end
        rotate_right_op: begin
          next_cur.status.carry = rotr_carry;
          if (REQ.dest == DEST_FILE) begin
            next_cur.file_wr = 1'h1;
            next_cur.file_data = rotr_result;
          end else begin
            next_cur.acc = rotr_result;
          end
        end
        literal_minus_accumulator_op: begin
          next_cur.acc = sub_diff;
          next_cur.status.carry = sub_carry;
          next_cur.status.nibble_carry_flag = sub_nibble;
          next_cur.status.zero = sub_zero;
        end
        OP_SLEEP: begin
          // Clear wins over the prescaler wrap in the same cycle
          next_cur.watchdog_counter = WDT_CLEAR;
          next_cur.prescale = PRESCALE_CLEAR;
          next_cur.status.timeout_flag_n = TIMEOUT_N_SLEEP;
          next_cur.status.powerdown_flag_n = POWERDOWN_N_SLEEP;
          next_cur.asleep = 1'h1;
        end
        default: begin
          next_cur.file_wr = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cur.acc <= ACC_RESET;
      cur.status.carry <= FLAG_RESET;
      cur.status.nibble_carry_flag <= FLAG_RESET;
      cur.status.zero <= FLAG_RESET;
      cur.status.timeout_flag_n <= FLAG_N_RESET;
      cur.status.powerdown_flag_n <= FLAG_N_RESET;
      cur.asleep <= 1'h0;
      cur.watchdog_counter <= WDT_CLEAR;
      cur.prescale <= PRESCALE_CLEAR;
      cur.file_wr <= 1'h0;
      cur.file_data <= FILE_DATA_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REQ_READY = !cur.asleep;
  assign FILE_WR_EN = cur.file_wr;
  assign FILE_WR_DATA = cur.file_data;
  assign ACC = cur.acc;
  assign STATUS = cur.status;
  assign WDT_COUNT = cur.watchdog_counter;
  // Oscillator gate; stays off until reset since wake-up is elsewhere
  assign OSC_RUN = !cur.asleep;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  logic do_rotl;
  logic do_rotr;
  logic do_sub;
  logic do_sleep;

  assign do_rotl = take && (REQ.code == rotate_left_op);
  assign do_rotr = take && (REQ.code == rotate_right_op);
  assign do_sub = take && (REQ.code == literal_minus_accumulator_op);
  assign do_sleep = take && (REQ.code == OP_SLEEP);

  sequence s_enter_sleep;
    do_sleep ##1 (cur.asleep && !OSC_RUN);
  endsequence

  sequence s_stay_halted;
    (!OSC_RUN && !REQ_READY && !FILE_WR_EN)[*8];
  endsequence

  property p_rotl_acc;
    do_rotl && (REQ.dest == DEST_ACC) |=>
      ACC == {$past(REQ.operand[6:0]), $past(cur.status.carry)}
      && !FILE_WR_EN;
  endproperty
  a_rotl_acc: assert property (p_rotl_acc)
    else $error("left rotate into accumulator wrong");

  property p_rotl_file;
    do_rotl && (REQ.dest == DEST_FILE) |=>
      FILE_WR_EN && ACC == $past(ACC)
      && FILE_WR_DATA == {$past(REQ.operand[6:0]), $past(cur.status.carry)};
  endproperty
  a_rotl_file: assert property (p_rotl_file)
    else $error("left rotate file write-back wrong");

  property p_rotr_acc;
    do_rotr && (REQ.dest == DEST_ACC) |=>
      ACC == {$past(cur.status.carry), $past(REQ.operand[7:1])}
      && !FILE_WR_EN;
  endproperty
  a_rotr_acc: assert property (p_rotr_acc)
    else $error("right rotate into accumulator wrong");

  property p_rotr_file;
    do_rotr && (REQ.dest == DEST_FILE) |=>
      FILE_WR_EN && ACC == $past(ACC)
      && FILE_WR_DATA == {$past(cur.status.carry), $past(REQ.operand[7:1])};
  endproperty
  a_rotr_file: assert property (p_rotr_file)
    else $error("right rotate file write-back wrong");

  property p_rot_carry;
    (do_rotl |=> STATUS.carry == $past(REQ.operand[7]))
    and (do_rotr |=> STATUS.carry == $past(REQ.operand[0]));
  endproperty
  a_rot_carry: assert property (p_rot_carry)
    else $error("rotate carry out wrong");

  property p_sleep_wdt;
    do_sleep |=> WDT_COUNT == WDT_CLEAR && cur.prescale == PRESCALE_CLEAR
      ##1 cur.prescale == 8'h01;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt)
    else $error("sleep did not clear watchdog");

  property p_sleep_to;
    do_sleep |=> STATUS.timeout_flag_n == TIMEOUT_N_SLEEP;
  endproperty
  a_sleep_to: assert property (p_sleep_to)
    else $error("sleep did not set timeout bit");

  property p_sleep_pd;
    do_sleep |=> STATUS.powerdown_flag_n == POWERDOWN_N_SLEEP
      && $fell(OSC_RUN);
  endproperty
  a_sleep_pd: assert property (p_sleep_pd)
    else $error("sleep did not clear power-down bit");

  property p_sleep_halt;
    s_enter_sleep |-> ##1 s_stay_halted;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("core kept running after sleep");

  property p_sub_value;
    do_sub |=> ACC == 8'($past(REQ.literal) - $past(ACC)) && !FILE_WR_EN;
  endproperty
  a_sub_value: assert property (p_sub_value)
    else $error("literal minus accumulator wrong");

  property p_sub_dest;
    do_sub && (REQ.dest == DEST_FILE) |=> !FILE_WR_EN
      && ACC == 8'($past(REQ.literal) - $past(ACC));
  endproperty
  a_sub_dest: assert property (p_sub_dest)
    else $error("subtract ignored accumulator destination");

  property p_sub_flags;
    do_sub |=>
      STATUS.carry == ($past(ACC) <= $past(REQ.literal))
      && STATUS.nibble_carry_flag ==
        ($past(ACC[3:0]) <= $past(REQ.literal[3:0]))
      && STATUS.zero == ($past(REQ.literal) == $past(ACC));
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("subtract flags wrong");

endmodule

// >>> rtl/core_ops_pkg.sv
// Shared types and constants of the rotate, subtract and sleep unit.
// Assumes one 20 MHz core clock and a synchronous active-high reset.
package core_ops_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and encodings
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;
  localparam logic ROT_LEFT = 1'h0;
  localparam logic ROT_RIGHT = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and forced values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_TOP = 8'hFF;
  localparam logic [7:0] FILE_DATA_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'h0;
  localparam logic FLAG_N_RESET = 1'h1;
  localparam logic TIMEOUT_N_SLEEP = 1'h1;
  localparam logic POWERDOWN_N_SLEEP = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Operations and carriers
  typedef enum logic [2:0] {
    OP_NONE,
    rotate_left_op,
    rotate_right_op,
    literal_minus_accumulator_op,
    OP_SLEEP
  } op_code_type;

  typedef struct packed {
    logic valid;
    op_code_type code;
    logic dest;
    logic [7:0] literal;
    logic [7:0] operand;
  } op_req_type;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } status_type;

endpackage

// >>> rtl/rotate_through_carry.sv
// Nine-bit rotate of a file operand through the carry bit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module rotate_through_carry #(
  parameter logic RIGHT = 1'h0
) (
  // Operand in
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // Result out
  output logic [7:0] result,
  output logic carry_out
);
  import core_ops_pkg::*;

  always_comb begin
    if (RIGHT == ROT_RIGHT) begin
      result = {carry_in, operand[7:1]};
      carry_out = operand[0];
    end else begin
      result = {operand[6:0], carry_in};
      carry_out = operand[7];
    end
  end

endmodule

// >>> rtl/literal_subtractor.sv
// Literal minus accumulator with borrow-style carry flags.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module literal_subtractor (
  // Operands
  input wire logic [7:0] literal,
  input wire logic [7:0] acc,
  // Result and flags
  output logic [7:0] diff,
  output logic carry,
  output logic nibble_carry,
  output logic zero
);
  import core_ops_pkg::*;

  logic [8:0] wide;
  logic [4:0] low;

  always_comb begin
    // Two's complement sum; carry out set means no borrow
    wide = {1'h0, literal} + {1'h0, ~acc} + 9'h001;
    low = {1'h0, literal[3:0]} + {1'h0, ~acc[3:0]} + 5'h01;
    diff = wide[7:0];
    carry = wide[8];
    nibble_carry = low[4];
    zero = (wide[7:0] == 8'h00);
  end

endmodule

// >>> verif/rotate_subtract_sleep_ops_tb.sv
// Self-checking bench of the rotate, subtract and sleep unit.
// Assumes core_ops_unit from rtl/; inputs change on falling edges.
`timescale 1ns/1ps
module rotate_subtract_sleep_ops_tb;
  import core_ops_pkg::*;

`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end

  typedef struct packed {
    logic valid;
    op_code_type code;
    logic dest;
    logic [7:0] lit;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [2:0] flags;
    logic wr;
    logic [7:0] wd;
  } row_type;

  logic CLK_SYS;
  logic RST;
  op_req_type REQ;
  logic REQ_READY;
  logic FILE_WR_EN;
  logic [7:0] FILE_WR_DATA;
  logic [7:0] ACC;
  status_type STATUS;
  logic [7:0] WDT_COUNT;
  logic OSC_RUN;
  int err_count;
  int checks_done;
  row_type rows[$];

  core_ops_unit core_ops_unit_inst (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .REQ(REQ),
    .REQ_READY(REQ_READY),
    .FILE_WR_EN(FILE_WR_EN),
    .FILE_WR_DATA(FILE_WR_DATA),
    .ACC(ACC),
    .STATUS(STATUS),
    .WDT_COUNT(WDT_COUNT),
    .OSC_RUN(OSC_RUN)
  );

  initial begin
    CLK_SYS = 1'h0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic put(input row_type r);
    REQ = '{r.valid, r.code, r.dest, r.lit, r.opnd};
  endtask

  // Prescaler must roll over once so the counter has something to clear
  task automatic wait_wdt;
    int n;
    n = 0;
    while (WDT_COUNT === 8'h00 && n < 1000) begin
      @(negedge CLK_SYS);
      n++;
    end
    if (n >= 1000) begin
      err_count++;
      $display("ERROR watchdog expected nonzero seen 0");
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checks_done = 0;
    RST = 1'h1;
    REQ = '0;
    // Flags column is {carry, nibble carry, zero}; chained state
    rows.push_back('{1'h1, literal_minus_accumulator_op, 1'h0, 8'h05,
      8'h00, 8'h05, 3'h6, 1'h0, 8'h00});
    rows.push_back('{1'h1, literal_minus_accumulator_op, 1'h0, 8'h03,
      8'h00, 8'hFE, 3'h0, 1'h0, 8'h00});
    rows.push_back('{1'h1, rotate_left_op, 1'h1, 8'h00,
      8'hE6, 8'hFE, 3'h4, 1'h1, 8'hCC});
    rows.push_back('{1'h1, rotate_left_op, 1'h0, 8'h00,
      8'h80, 8'h01, 3'h4, 1'h0, 8'hCC});
    rows.push_back('{1'h1, rotate_right_op, 1'h1, 8'h00,
      8'h01, 8'h01, 3'h4, 1'h1, 8'h80});
    rows.push_back('{1'h1, rotate_right_op, 1'h0, 8'h00,
      8'h02, 8'h81, 3'h0, 1'h0, 8'h80});
    rows.push_back('{1'h1, literal_minus_accumulator_op, 1'h0, 8'h81,
      8'h00, 8'h00, 3'h7, 1'h0, 8'h80});
    rows.push_back('{1'h1, literal_minus_accumulator_op, 1'h1, 8'h10,
      8'h00, 8'h10, 3'h6, 1'h0, 8'h80});
    rows.push_back('{1'h1, literal_minus_accumulator_op, 1'h0, 8'h0F,
      8'h00, 8'hFF, 3'h2, 1'h0, 8'h80});
    rows.push_back('{1'h1, OP_NONE, 1'h1, 8'h00,
      8'h00, 8'hFF, 3'h2, 1'h0, 8'h80});
    rows.push_back('{1'h0, literal_minus_accumulator_op, 1'h0, 8'h55,
      8'h00, 8'hFF, 3'h2, 1'h0, 8'h80});
    // Zero result of a rotate must leave the zero flag alone
    rows.push_back('{1'h1, rotate_left_op, 1'h0, 8'h00,
      8'h00, 8'h00, 3'h2, 1'h0, 8'h80});
    repeat (8) @(negedge CLK_SYS);
    `CHK("reset acc", 8'h00, ACC)
    `CHK("reset status", 5'h03, STATUS)
    `CHK("reset wdt", 8'h00, WDT_COUNT)
    `CHK("reset wr_en", 1'h0, FILE_WR_EN)
    `CHK("reset wr_data", 8'h00, FILE_WR_DATA)
    `CHK("reset osc", 1'h1, OSC_RUN)
    `CHK("reset ready", 1'h1, REQ_READY)
    RST = 1'h0;
    for (int k = 0; k < rows.size(); k++) begin
      put(rows[k]);
      @(negedge CLK_SYS);
      `CHK("acc", rows[k].acc, ACC)
      `CHK("flags", rows[k].flags, STATUS[4:2])
      `CHK("wr_en", rows[k].wr, FILE_WR_EN)
      `CHK("wr_data", rows[k].wd, FILE_WR_DATA)
    end
    REQ = '0;
    wait_wdt();
    // Park the prescaler mid-count so a missed clear wraps during sleep
    repeat (128) @(negedge CLK_SYS);
    REQ = '{1'h1, OP_SLEEP, 1'h0, 8'h00, 8'h00};
    @(negedge CLK_SYS);
    `CHK("sleep wdt", 8'h00, WDT_COUNT)
    `CHK("sleep timeout", 1'h1, STATUS.timeout_flag_n)
    `CHK("sleep powerdown", 1'h0, STATUS.powerdown_flag_n)
    `CHK("sleep osc", 1'h0, OSC_RUN)
    `CHK("sleep ready", 1'h0, REQ_READY)
    // Uncleared prescaler would bump the counter well before this
    REQ = '{1'h1, literal_minus_accumulator_op, 1'h0, 8'h77, 8'h00};
    repeat (200) @(negedge CLK_SYS);
    `CHK("slept acc", 8'h00, ACC)
    `CHK("slept wdt", 8'h00, WDT_COUNT)
    REQ = '{1'h1, rotate_left_op, 1'h1, 8'h00, 8'hFF};
    @(negedge CLK_SYS);
    `CHK("slept wr_en", 1'h0, FILE_WR_EN)
    `CHK("slept flags", 3'h2, STATUS[4:2])
    RST = 1'h1;
    @(negedge CLK_SYS);
    `CHK("rearm ready", 1'h1, REQ_READY)
    `CHK("rearm osc", 1'h1, OSC_RUN)
    `CHK("rearm status", 5'h03, STATUS)
    RST = 1'h0;
    REQ = '{1'h1, literal_minus_accumulator_op, 1'h0, 8'h00, 8'h00};
    @(negedge CLK_SYS);
    `CHK("zero acc", 8'h00, ACC)
    `CHK("zero flags", 3'h7, STATUS[4:2])
    finish_test();
  end

endmodule
